// *** hw/ssp_pkg.sv ***
package ssp_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TXDATA = 8'h04;
    localparam logic [7:0] ADDR_RXBUF  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQEN  = 8'h10;
    localparam logic [7:0] ADDR_IRQCLR = 8'h14;
    localparam logic [7:0] ADDR_STATE  = 8'h18;

    // Control register fields
    localparam int         CTRL_MASTER_BIT = 0;
    localparam int         CTRL_POL_BIT    = 1;
    localparam logic       MASTER_RST      = 1'b0;
    localparam logic       POL_RST         = 1'b0;

    // Event bits, shared by status, enable and clear registers
    localparam int         EV_DONE = 0;
    localparam int         EV_COLL = 1;
    localparam int         EV_W    = 2;
    localparam logic [1:0] EV_RST  = 2'h0;

    // State register fields
    localparam int         STATE_SEL_BIT = 8;

    // Reset values of the data paths
    localparam logic [31:0] DAT_RST    = 32'h0000_0000;
    localparam logic        LINE_IDLE  = 1'b1;

    // Port states, one-hot
    typedef enum logic [1:0] {
        SSP_IDLE = 2'b01,
        SSP_ACT  = 2'b10
    } ssp_mode_t;

endpackage : ssp_pkg

// *** hw/ssp_slave.sv ***
`timescale 1ns/10ps

module ssp_slave #(
    parameter int WORD_W = 8
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Serial link pins
    input  wire logic        serial_shift_clock_in,
    input  wire logic        slave_serial_data_in,
    input  wire logic        slave_select_input,
    output logic             slave_serial_data_out,
    output logic             slave_serial_data_oe_out,
    // Interrupt
    output logic             irq_out
);

    localparam int CNT_W = $clog2(WORD_W + 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_W - 1);

    // Whole module state
    typedef struct packed {
        ssp_pkg::ssp_mode_t       mode;
        logic                     master_mode;
        logic                     pol;
        logic [WORD_W-1:0]        shift;
        logic [WORD_W-1:0]        rxbuf;
        logic [CNT_W-1:0]         bit_cnt;
        logic [ssp_pkg::EV_W-1:0] status;
        logic [ssp_pkg::EV_W-1:0] ien;
        logic                     done;
        logic                     ack;
        logic [31:0]              dat;
        logic                     irq;
        logic                     sdo;
        logic                     sdo_oe;
        logic [2:0]               sck_sync;
        logic [1:0]               cs_sync;
        logic [1:0]               sdi_sync;
    } ssp_state_t;

    ssp_state_t st;
    ssp_state_t next_st;

    // Select decode: active level set by software, slave mode only
    function automatic logic ssp_selected(input logic cs, input logic pol, input logic master);
        ssp_selected = (cs == pol) && !master;
    endfunction : ssp_selected

    logic              sel_now;
    logic              sck_rise;
    logic              sck_fall;
    logic              bus_req;
    logic [WORD_W-1:0] shifted;

    // Synchronised pin views, stage two onward only
    assign sel_now  = ssp_selected(st.cs_sync[1], st.pol, st.master_mode);
    assign sck_rise = st.sck_sync[1] && !st.sck_sync[2];
    assign sck_fall = !st.sck_sync[1] && st.sck_sync[2];
    assign bus_req  = wb_cyc_in && wb_stb_in && !st.ack;
    assign shifted  = {st.shift[WORD_W-2:0], st.sdi_sync[1]};

    // Next-state logic
    always_comb begin
        logic [ssp_pkg::EV_W-1:0] ev_set;
        logic [ssp_pkg::EV_W-1:0] ev_clr;
        ev_set  = '0;
        ev_clr  = '0;
        next_st = st;

        // Pin synchronisers
        next_st.sck_sync = {st.sck_sync[1:0], serial_shift_clock_in};
        next_st.cs_sync  = {st.cs_sync[0], slave_select_input};
        next_st.sdi_sync = {st.sdi_sync[0], slave_serial_data_in};
        next_st.done     = 1'b0;

        // Link side
        case (st.mode)
            ssp_pkg::SSP_IDLE: begin
                if (sel_now) begin
                    next_st.mode    = ssp_pkg::SSP_ACT;
                    next_st.bit_cnt = CNT_ZERO;
                    next_st.sdo     = st.shift[WORD_W-1];
                    next_st.sdo_oe  = 1'b1;
                end else begin
                    next_st.sdo     = ssp_pkg::LINE_IDLE;
                    next_st.sdo_oe  = 1'b0;
                end
            end
            ssp_pkg::SSP_ACT: begin
                if (!sel_now) begin
                    next_st.mode   = ssp_pkg::SSP_IDLE;
                    next_st.sdo    = ssp_pkg::LINE_IDLE;
                    next_st.sdo_oe = 1'b0;
                end else if (sck_rise) begin
                    // Bit timed by the master's clock only
                    next_st.shift = shifted;
                    if (st.bit_cnt == CNT_LAST) begin
                        next_st.bit_cnt = CNT_ZERO;
                        next_st.rxbuf   = shifted;
                        next_st.done    = 1'b1;
                        ev_set[ssp_pkg::EV_DONE] = 1'b1;
                    end else begin
                        next_st.bit_cnt = st.bit_cnt + CNT_W'(1);
                    end
                end else if (sck_fall) begin
                    next_st.sdo = st.shift[WORD_W-1];
                end
            end
            default: begin
                next_st.mode   = ssp_pkg::SSP_IDLE;
                next_st.sdo_oe = 1'b0;
            end
        endcase

        // Bus side: answer one cycle after the request
        next_st.ack = bus_req;
        if (bus_req) begin
            next_st.dat = ssp_pkg::DAT_RST;
            case (wb_adr_in)
                ssp_pkg::ADDR_CTRL: begin
                    next_st.dat[ssp_pkg::CTRL_MASTER_BIT] = st.master_mode;
                    next_st.dat[ssp_pkg::CTRL_POL_BIT]    = st.pol;
                end
                ssp_pkg::ADDR_TXDATA: next_st.dat[WORD_W-1:0]        = st.shift;
                ssp_pkg::ADDR_RXBUF:  next_st.dat[WORD_W-1:0]        = st.rxbuf;
                ssp_pkg::ADDR_STATUS: next_st.dat[ssp_pkg::EV_W-1:0] = st.status;
                ssp_pkg::ADDR_IRQEN:  next_st.dat[ssp_pkg::EV_W-1:0] = st.ien;
                ssp_pkg::ADDR_STATE: begin
                    next_st.dat[CNT_W-1:0]            = st.bit_cnt;
                    next_st.dat[ssp_pkg::STATE_SEL_BIT] = (st.mode == ssp_pkg::SSP_ACT);
                end
                default: next_st.dat = ssp_pkg::DAT_RST;
            endcase
            if (wb_we_in && wb_sel_in[0]) begin
                case (wb_adr_in)
                    ssp_pkg::ADDR_CTRL: begin
                        next_st.master_mode = wb_dat_in[ssp_pkg::CTRL_MASTER_BIT];
                        next_st.pol         = wb_dat_in[ssp_pkg::CTRL_POL_BIT];
                    end
                    ssp_pkg::ADDR_TXDATA: begin
                        // Loading mid-transfer would corrupt the word
                        if (st.mode == ssp_pkg::SSP_IDLE) begin
                            next_st.shift = wb_dat_in[WORD_W-1:0];
                        end else begin
                            ev_set[ssp_pkg::EV_COLL] = 1'b1;
                        end
                    end
                    ssp_pkg::ADDR_IRQEN:  next_st.ien = wb_dat_in[ssp_pkg::EV_W-1:0];
                    ssp_pkg::ADDR_IRQCLR: ev_clr      = wb_dat_in[ssp_pkg::EV_W-1:0];
                    default: ;
                endcase
            end
        end

        // Sticky status, set wins over clear
        next_st.status = (st.status & ~ev_clr) | ev_set;
        next_st.irq    = |(next_st.status & next_st.ien);
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st             <= '0;
            st.mode        <= ssp_pkg::SSP_IDLE;
            st.master_mode <= ssp_pkg::MASTER_RST;
            st.pol         <= ssp_pkg::POL_RST;
            st.status      <= ssp_pkg::EV_RST;
            st.ien         <= ssp_pkg::EV_RST;
            st.dat         <= ssp_pkg::DAT_RST;
            st.sdo         <= ssp_pkg::LINE_IDLE;
            st.sck_sync    <= 3'h0;
            // Select synchroniser starts inactive, no false select after reset
            st.cs_sync     <= {$bits(st.cs_sync){~ssp_pkg::POL_RST}};
            st.sdi_sync    <= 2'h0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign wb_dat_out               = st.dat;
    assign wb_ack_out               = st.ack;
    assign slave_serial_data_out    = st.sdo;
    assign slave_serial_data_oe_out = st.sdo_oe;
    assign irq_out                  = st.irq;

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_master_mode_off: assert property (
        st.master_mode |=> st.mode == ssp_pkg::SSP_IDLE && !slave_serial_data_oe_out)
        else $error("port active while master mode set");

    chk_count_by_clock: assert property (
        (st.mode == ssp_pkg::SSP_ACT && sel_now && !sck_rise) |=> $stable(st.bit_cnt))
        else $error("bit count moved without a serial clock rise");

    chk_msb_out: assert property (
        (st.mode == ssp_pkg::SSP_ACT && sel_now && sck_fall)
            |=> slave_serial_data_out == $past(st.shift[WORD_W-1]) && slave_serial_data_oe_out)
        else $error("data output not the shift register MSB");

    chk_rx_replaces: assert property (
        st.done |-> st.shift == st.rxbuf && st.rxbuf == $past(shifted))
        else $error("shift register not replaced by received word");

    chk_flag_set: assert property (
        (st.mode == ssp_pkg::SSP_ACT && sel_now && sck_rise && st.bit_cnt == CNT_LAST)
            |=> st.done && st.status[ssp_pkg::EV_DONE] ##1 !st.done)
        else $error("complete flag not set at end of word");

    chk_irq_raised: assert property (
        (st.done && st.ien[ssp_pkg::EV_DONE]) |-> irq_out)
        else $error("interrupt missing after completion");

    chk_sel_level: assert property (
        $rose(st.mode == ssp_pkg::SSP_ACT)
            |-> $past(st.cs_sync[1]) == $past(st.pol) && !$past(st.master_mode))
        else $error("port enabled at the wrong select level");

    chk_out_release: assert property (
        !sel_now |=> !slave_serial_data_oe_out && slave_serial_data_out == ssp_pkg::LINE_IDLE)
        else $error("data output driven while unselected");

    chk_count_restart: assert property (
        (st.mode == ssp_pkg::SSP_IDLE && sel_now) |=> st.bit_cnt == CNT_ZERO)
        else $error("bit count not restarted on selection");

    chk_first_bit: assert property (
        (st.mode == ssp_pkg::SSP_IDLE && sel_now)
            |=> slave_serial_data_out == $past(st.shift[WORD_W-1]) && slave_serial_data_oe_out)
        else $error("first data bit not the shift register MSB");

    chk_out_steady: assert property (
        (st.mode == ssp_pkg::SSP_ACT && sel_now && !sck_fall) |=> $stable(slave_serial_data_out))
        else $error("data output moved without a serial clock fall");

    chk_oe_active: assert property (
        st.mode == ssp_pkg::SSP_ACT |-> slave_serial_data_oe_out)
        else $error("data output released while the port is active");

    chk_sample_in: assert property (
        (st.mode == ssp_pkg::SSP_ACT && sel_now && sck_rise)
            |=> st.shift[0] == $past(st.sdi_sync[1]))
        else $error("received bit not taken on a serial clock rise");

    chk_count_step: assert property (
        (st.mode == ssp_pkg::SSP_ACT && sel_now && sck_rise && st.bit_cnt != CNT_LAST)
            |=> st.bit_cnt == $past(st.bit_cnt) + CNT_W'(1))
        else $error("bit count did not step on a serial clock rise");

    chk_idle_quiet: assert property (
        (st.mode == ssp_pkg::SSP_IDLE && !sel_now) |=> st.mode == ssp_pkg::SSP_IDLE && !st.done)
        else $error("unselected port reacted to the link");

    chk_leave_active: assert property (
        (st.mode == ssp_pkg::SSP_ACT && !sel_now) |=> st.mode == ssp_pkg::SSP_IDLE)
        else $error("port stayed enabled after select went inactive");

    chk_rxbuf_hold: assert property (
        !st.done |-> $stable(st.rxbuf))
        else $error("read buffer changed outside a word end");

    chk_done_status: assert property (
        st.done |-> st.status[ssp_pkg::EV_DONE])
        else $error("complete flag missing at word end");

    chk_irq_level: assert property (
        irq_out == |(st.status & st.ien))
        else $error("interrupt level differs from enabled status");

    cov_word_done: cover property (st.done);
    cov_collision: cover property ($rose(st.status[ssp_pkg::EV_COLL]));
    cov_irq_rise:  cover property ($rose(irq_out));
    cov_two_words: cover property (st.done ##[1:1000] st.done);
    cov_cut_word:  cover property (
        st.mode == ssp_pkg::SSP_ACT && !sel_now && st.bit_cnt != CNT_ZERO);

endmodule : ssp_slave

// *** testbench/ssp_spi_master_model.sv ***
`timescale 1ns/10ps

module ssp_spi_master_model (
    // Clock and polarity
    input  wire logic ref_clk_in,
    input  wire logic pol_in,
    // Link pins
    input  wire logic miso_in,
    output logic      sck_out,
    output logic      mosi_out,
    output logic      sel_out
);
    localparam int HALF = 16; // 80 ns half period, well under a quarter rate
    logic sel_q = 1'b0;

    // Select level follows the configured active polarity
    assign sel_out = sel_q ? pol_in : ~pol_in;

    // Idle levels at time zero
    initial begin
        sck_out  = 1'b0;
        mosi_out = 1'b0;
    end

    // Wait system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : tick

    // Clock edges with the slave not selected
    task automatic idle_clocks(input int n);
        repeat (n) begin
            sck_out <= 1'b1;
            tick(HALF);
            sck_out <= 1'b0;
            tick(HALF);
        end
    endtask : idle_clocks

    // One frame, MSB first; fewer than 8 bits aborts it
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        sel_q <= 1'b1; // Select held through the word
        for (int i = 7; i >= 8 - nbits; i--) begin
            mosi_out <= tx[i];
            tick(HALF);
            sck_out <= 1'b1;
            rx[i] = miso_in;
            tick(HALF);
            sck_out <= 1'b0;
        end
        tick(HALF);
        sel_q    <= 1'b0;
        mosi_out <= ~mosi_out; // Released line shows no stale data
        tick(4);
    endtask : xfer
endmodule : ssp_spi_master_model

// *** testbench/spi_slave_port_tb.sv ***
`timescale 1ns/10ps

module spi_slave_port_tb;
    logic        clk = 1'b0;
    logic        rst_n, cyc, stb, we, ack, sck, mosi, sel, sdo, oe, irq, pol;
    logic [7:0]  adr, rx;
    logic [3:0]  lanes;
    logic [31:0] dat_w, dat_r, q;
    int          n_errors = 0;
    int          n_compared = 0;
    wire         miso = oe ? sdo : 1'b1; // Weak pull-up when released

    // System clock, 200 MHz
    always #2.5 clk = ~clk;

    ssp_slave i_ssp_slave (.ref_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(lanes),
        .wb_dat_in(dat_w), .wb_dat_out(dat_r), .wb_ack_out(ack),
        .serial_shift_clock_in(sck), .slave_serial_data_in(mosi),
        .slave_select_input(sel), .slave_serial_data_out(sdo),
        .slave_serial_data_oe_out(oe), .irq_out(irq));

    ssp_spi_master_model i_ssp_spi_master_model (.ref_clk_in(clk), .pol_in(pol),
        .miso_in(miso), .sck_out(sck), .mosi_out(mosi), .sel_out(sel));

    // Compare and count
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Classic Wishbone single cycle, waits for ack with no limit of its own
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        lanes <= 4'hF;
        dat_w <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1);
        q = dat_r;
        check("bus latency", k, 32'h0000_0002);
        cyc   <= 1'b0;
        stb   <= 1'b0;
        we    <= 1'b0;
        lanes <= 4'h0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0000_0000);
        check(what, q, exp);
    endtask : rd_chk

    // Reset values and an unmapped place
    task automatic test_reset;
        repeat (2) @(posedge clk);
        check("oe after reset", oe, 1'b0);
        rd_chk(ssp_pkg::ADDR_STATE, 32'h0000_0000, "state");
        rd_chk(ssp_pkg::ADDR_CTRL, 32'h0000_0000, "ctrl");
        rd_chk(ssp_pkg::ADDR_STATUS, 32'h0000_0000, "status");
        rd_chk(8'h1C, 32'h0000_0000, "unmapped");
        check("oe idle", oe, 1'b0);
        check("irq idle", irq, 1'b0);
        $display("test reset done");
    endtask : test_reset

    // Two frames back to back with the interrupt enabled
    task automatic test_xfer;
        wr(ssp_pkg::ADDR_IRQEN, 32'h0000_0001);
        wr(ssp_pkg::ADDR_TXDATA, 32'h0000_00A5);
        i_ssp_spi_master_model.xfer(8'h3C, 8, rx);
        check("miso word", rx, 8'hA5);
        check("irq set", irq, 1'b1);
        rd_chk(ssp_pkg::ADDR_RXBUF, 32'h0000_003C, "rxbuf");
        rd_chk(ssp_pkg::ADDR_STATUS, 32'h0000_0001, "done");
        rd_chk(ssp_pkg::ADDR_TXDATA, 32'h0000_003C, "shift");
        i_ssp_spi_master_model.xfer(8'h81, 8, rx);
        check("miso second", rx, 8'h3C);
        rd_chk(ssp_pkg::ADDR_RXBUF, 32'h0000_0081, "rxbuf 2");
        wr(ssp_pkg::ADDR_IRQCLR, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check("irq clr", irq, 1'b0);
        rd_chk(ssp_pkg::ADDR_STATUS, 32'h0000_0000, "cleared");
        $display("test xfer done");
    endtask : test_xfer

    // Completion with the interrupt masked
    task automatic test_mask;
        wr(ssp_pkg::ADDR_IRQEN, 32'h0000_0000);
        i_ssp_spi_master_model.xfer(8'h5A, 8, rx);
        check("irq masked", irq, 1'b0);
        rd_chk(ssp_pkg::ADDR_STATUS, 32'h0000_0001, "done masked");
        wr(ssp_pkg::ADDR_IRQCLR, 32'h0000_0001);
        $display("test mask done");
    endtask : test_mask

    // Master-mode bit, polarity, stray clocks and an aborted frame
    task automatic test_mode;
        wr(ssp_pkg::ADDR_CTRL, 32'h0000_0001);
        i_ssp_spi_master_model.xfer(8'hF0, 8, rx);
        check("slave off", rx, 8'hFF);
        rd_chk(ssp_pkg::ADDR_STATUS, 32'h0000_0000, "off status");
        wr(ssp_pkg::ADDR_CTRL, 32'h0000_0002);
        pol <= 1'b1;
        repeat (8) @(posedge clk);
        i_ssp_spi_master_model.idle_clocks(3);
        i_ssp_spi_master_model.xfer(8'h0F, 3, rx);
        check("miso partial", rx, 8'h40);
        rd_chk(ssp_pkg::ADDR_STATUS, 32'h0000_0000, "partial");
        wr(ssp_pkg::ADDR_TXDATA, 32'h0000_0096);
        i_ssp_spi_master_model.xfer(8'hC3, 8, rx);
        check("miso high pol", rx, 8'h96);
        rd_chk(ssp_pkg::ADDR_RXBUF, 32'h0000_00C3, "rxbuf pol");
        fork
            i_ssp_spi_master_model.xfer(8'h3C, 8, rx);
            begin
                repeat (40) @(posedge clk);
                wr(ssp_pkg::ADDR_TXDATA, 32'h0000_0011);
            end
        join
        check("miso no reload", rx, 8'hC3);
        rd_chk(ssp_pkg::ADDR_STATUS, 32'h0000_0003, "collision");
        $display("test mode done");
    endtask : test_mode

    // Counts, verdict and end of run
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        rst_n = 1'b0;
        cyc   = 1'b0;
        stb   = 1'b0;
        we    = 1'b0;
        adr   = 8'h00;
        dat_w = 32'h0000_0000;
        lanes = 4'h0;
        pol   = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        test_reset;
        test_xfer;
        test_mask;
        test_mode;
        give_verdict;
    end

    // Watchdog, far beyond the expected few thousand cycles
    initial begin
        #200_000;
        n_errors++;
        give_verdict;
    end
endmodule : spi_slave_port_tb
